// ===== core/lbp_core.sv
module lbp_core (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wbe,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    input wire logic slow_clk_pin,
    input wire logic wdt_timeout,
    output logic pwm_out
);
    // Register state
    logic [1:0] beh_reg, beh_next;
    logic clksel_reg, clksel_next;
    logic align_reg, align_next;
    logic upd_reg, upd_next;
    lbp_pkg::lbp_bounds_s bnd_reg, bnd_next, bndh_reg, bndh_next;
    lbp_pkg::lbp_wait_s wt_reg, wt_next, wth_reg, wth_next;
    logic [31:0] rdata_reg, rdata_next;
    // PWM state
    logic [7:0] cnt_reg, cnt_next;
    logic [7:0] duty_reg, duty_next;
    logic [11:0] pre_reg, pre_next;
    logic [11:0] hold_reg, hold_next;
    lbp_pkg::lbp_ramp_e ramp_reg, ramp_next;
    lbp_pkg::lbp_ramp_e dir_reg, dir_next;
    logic out_reg, out_next;
    // Slow clock synchroniser and edge detect
    logic s1_reg, s2_reg, s3_reg;
    logic tick, period_end, running;

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
            s3_reg <= 1'b0;
        end
        else
        begin
            s1_reg <= slow_clk_pin;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    // Base tick; clock choice only matters in blink
    always_comb
    begin
        running = (beh_reg != lbp_pkg::LBP_OFF) && !align_reg;
        if (beh_reg == lbp_pkg::LBP_BLINK && !clksel_reg)
            tick = s2_reg && !s3_reg;
        else
            tick = 1'b1;
    end

    // Prescaler and period counter
    always_comb
    begin
        pre_next = pre_reg;
        cnt_next = cnt_reg;
        period_end = 1'b0;
        if (!running)
        begin
            pre_next = 12'h000;
            cnt_next = 8'h00;
        end
        else if (tick)
        begin
            if (beh_reg == lbp_pkg::LBP_BLINK && pre_reg < wt_reg.bottom_wait_periods)
                pre_next = pre_reg + 12'h001;
            else
            begin
                pre_next = 12'h000;
                cnt_next = cnt_reg + 8'h01;
                period_end = (cnt_reg == 8'hFF);
            end
        end
    end

    // Breathing ramp: hold at bounds for wait plus one periods
    always_comb
    begin
        duty_next = duty_reg;
        hold_next = hold_reg;
        ramp_next = ramp_reg;
        dir_next = dir_reg;
        if (!running)
        begin
            duty_next = 8'h00;
            hold_next = 12'h000;
            ramp_next = lbp_pkg::LBP_UP;
            dir_next = lbp_pkg::LBP_UP;
        end
        else if (period_end && beh_reg == lbp_pkg::LBP_BREATHE)
        begin
            unique case (ramp_reg)
                lbp_pkg::LBP_UP:
                begin
                    if (duty_reg >= bnd_reg.upper)
                    begin
                        ramp_next = lbp_pkg::LBP_HOLD;
                        dir_next = lbp_pkg::LBP_DOWN;
                        hold_next = wt_reg.top_wait_periods;
                    end
                    else
                        duty_next = duty_reg + 8'h01;
                end
                lbp_pkg::LBP_DOWN:
                begin
                    if (duty_reg <= bnd_reg.lower)
                    begin
                        ramp_next = lbp_pkg::LBP_HOLD;
                        dir_next = lbp_pkg::LBP_UP;
                        hold_next = wt_reg.bottom_wait_periods;
                    end
                    else
                        duty_next = duty_reg - 8'h01;
                end
                lbp_pkg::LBP_HOLD:
                begin
                    // Zero count bypasses the wait: step on this period
                    if (hold_reg == 12'h000)
                    begin
                        ramp_next = dir_reg;
                        if (dir_reg == lbp_pkg::LBP_DOWN)
                            duty_next = duty_reg - 8'h01;
                        else
                            duty_next = duty_reg + 8'h01;
                    end
                    else
                        hold_next = hold_reg - 12'h001;
                end
                default:
                    ramp_next = lbp_pkg::LBP_UP;
            endcase
        end
    end

    // Output stage per behaviour
    always_comb
    begin
        unique case (beh_reg)
            lbp_pkg::LBP_ON: out_next = 1'b1;
            lbp_pkg::LBP_BLINK: out_next = running && (cnt_reg < bnd_reg.lower);
            lbp_pkg::LBP_BREATHE: out_next = running && (cnt_reg < duty_reg);
            default: out_next = 1'b0;
        endcase
    end

    // Register writes, holding copies and commits
    always_comb
    begin
        beh_next = beh_reg;
        clksel_next = clksel_reg;
        align_next = align_reg;
        upd_next = upd_reg;
        bndh_next = bndh_reg;
        wth_next = wth_reg;
        bnd_next = bnd_reg;
        wt_next = wt_reg;
        rdata_next = 32'h00000000;
        if (wr && addr == lbp_pkg::CFG_OFFSET && wbe[0])
        begin
            beh_next = wdata[lbp_pkg::BEH_LSB +: 2];
            clksel_next = wdata[lbp_pkg::CLKSEL_BIT];
            align_next = wdata[lbp_pkg::ALIGN_BIT];
        end
        if (wr && addr == lbp_pkg::BOUNDS_OFFSET)
        begin
            if (wbe[0])
                bndh_next.lower = wdata[7:0];
            if (wbe[1])
                bndh_next.upper = wdata[15:8];
        end
        if (wr && addr == lbp_pkg::WAIT_OFFSET)
        begin
            if (wbe[0])
                wth_next[7:0] = wdata[7:0];
            if (wbe[1])
                wth_next[15:8] = wdata[15:8];
            if (wbe[2])
                wth_next[23:16] = wdata[23:16];
        end
        if (period_end)
        begin
            bnd_next = bndh_reg;
            if (upd_reg)
            begin
                wt_next = wth_reg;
                upd_next = 1'b0;
            end
        end
        // A set arriving with the commit wins over the clear
        if (wr && addr == lbp_pkg::CFG_OFFSET && wbe[0] && wdata[lbp_pkg::UPDATE_BIT])
            upd_next = 1'b1;
        if (wdt_timeout)
            beh_next = lbp_pkg::LBP_ON;
        if (rd)
        begin
            unique case (addr)
                lbp_pkg::CFG_OFFSET:
                    rdata_next = {25'h0, upd_reg, 2'h0, align_reg, clksel_reg, beh_reg};
                lbp_pkg::BOUNDS_OFFSET: rdata_next = {16'h0000, bnd_reg};
                lbp_pkg::WAIT_OFFSET: rdata_next = {8'h00, wt_reg};
                default: rdata_next = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            beh_reg <= lbp_pkg::BEH_RESET;
            clksel_reg <= 1'b0;
            align_reg <= 1'b0;
            upd_reg <= 1'b0;
            bnd_reg <= lbp_pkg::BOUNDS_RESET;
            bndh_reg <= lbp_pkg::BOUNDS_RESET;
            wt_reg <= lbp_pkg::WAIT_RESET;
            wth_reg <= lbp_pkg::WAIT_RESET;
            rdata_reg <= 32'h00000000;
            cnt_reg <= 8'h00;
            duty_reg <= 8'h00;
            pre_reg <= 12'h000;
            hold_reg <= 12'h000;
            ramp_reg <= lbp_pkg::LBP_UP;
            dir_reg <= lbp_pkg::LBP_UP;
            out_reg <= 1'b0;
        end
        else
        begin
            beh_reg <= beh_next;
            clksel_reg <= clksel_next;
            align_reg <= align_next;
            upd_reg <= upd_next;
            bnd_reg <= bnd_next;
            bndh_reg <= bndh_next;
            wt_reg <= wt_next;
            wth_reg <= wth_next;
            rdata_reg <= rdata_next;
            cnt_reg <= cnt_next;
            duty_reg <= duty_next;
            pre_reg <= pre_next;
            hold_reg <= hold_next;
            ramp_reg <= ramp_next;
            dir_reg <= dir_next;
            out_reg <= out_next;
        end
    end

    assign rdata = rdata_reg;
    assign pwm_out = out_reg;

    // Checks
    a_align_holds: assert property (@(posedge clk) disable iff (!rstn)
        align_reg |=> (cnt_reg == 8'h00 && duty_reg == 8'h00))
        else $error("counters moved while aligned");
    a_off_clears: assert property (@(posedge clk) disable iff (!rstn)
        beh_reg == lbp_pkg::LBP_OFF |=> (cnt_reg == 8'h00 && !pwm_out))
        else $error("off behaviour did not clear");
    a_wdt_forces: assert property (@(posedge clk) disable iff (!rstn)
        wdt_timeout |=> beh_reg == lbp_pkg::LBP_ON ##1 pwm_out)
        else $error("timeout did not force on");
    a_bounds_commit: assert property (@(posedge clk) disable iff (!rstn)
        period_end && !(wr && addr == lbp_pkg::BOUNDS_OFFSET) |=> bnd_reg == bndh_reg)
        else $error("bounds not committed");
    a_wait_gated: assert property (@(posedge clk) disable iff (!rstn)
        !(period_end && upd_reg) |=> $stable(wt_reg))
        else $error("wait changed without request");
    a_upd_clear: assert property (@(posedge clk) disable iff (!rstn)
        period_end && upd_reg && !wr |=> !upd_reg)
        else $error("update request not cleared");
    a_bounds_read: assert property (@(posedge clk) disable iff (!rstn)
        rd && addr == lbp_pkg::BOUNDS_OFFSET |=> rdata[15:0] == $past(bnd_reg))
        else $error("bounds read wrong");
    a_running_counts: assert property (@(posedge clk) disable iff (!rstn)
        running && tick && beh_reg == lbp_pkg::LBP_BREATHE |=> cnt_reg == $past(cnt_reg) + 8'h01)
        else $error("counter did not advance");
    a_on_output: assert property (@(posedge clk) disable iff (!rstn)
        beh_reg == lbp_pkg::LBP_ON && !wr |=> pwm_out)
        else $error("on behaviour not driving");
    // Ramp turning points, waits and blink gating
    a_peak_turn: assert property (@(posedge clk) disable iff (!rstn)
        period_end && beh_reg == lbp_pkg::LBP_BREATHE && ramp_reg == lbp_pkg::LBP_UP
        && duty_reg >= bnd_reg.upper |=> ramp_reg == lbp_pkg::LBP_HOLD
        && dir_reg == lbp_pkg::LBP_DOWN && hold_reg == $past(wt_reg.top_wait_periods))
        else $error("peak did not start hold");
    a_trough_turn: assert property (@(posedge clk) disable iff (!rstn)
        period_end && beh_reg == lbp_pkg::LBP_BREATHE && ramp_reg == lbp_pkg::LBP_DOWN
        && duty_reg <= bnd_reg.lower |=> ramp_reg == lbp_pkg::LBP_HOLD
        && dir_reg == lbp_pkg::LBP_UP && hold_reg == $past(wt_reg.bottom_wait_periods))
        else $error("trough did not start hold");
    a_hold_count: assert property (@(posedge clk) disable iff (!rstn)
        period_end && beh_reg == lbp_pkg::LBP_BREATHE && ramp_reg == lbp_pkg::LBP_HOLD
        && hold_reg != 12'h000 |=> ramp_reg == lbp_pkg::LBP_HOLD
        && hold_reg == $past(hold_reg) - 12'h001)
        else $error("hold count did not step");
    a_hold_down: assert property (@(posedge clk) disable iff (!rstn)
        period_end && beh_reg == lbp_pkg::LBP_BREATHE && ramp_reg == lbp_pkg::LBP_HOLD
        && hold_reg == 12'h000 && dir_reg == lbp_pkg::LBP_DOWN
        |=> duty_reg == $past(duty_reg) - 8'h01)
        else $error("duty did not fall after hold");
    a_hold_up: assert property (@(posedge clk) disable iff (!rstn)
        period_end && beh_reg == lbp_pkg::LBP_BREATHE && ramp_reg == lbp_pkg::LBP_HOLD
        && hold_reg == 12'h000 && dir_reg == lbp_pkg::LBP_UP
        |=> duty_reg == $past(duty_reg) + 8'h01)
        else $error("duty did not rise after hold");
    a_slow_tick: assert property (@(posedge clk) disable iff (!rstn)
        beh_reg == lbp_pkg::LBP_BLINK && !clksel_reg && running && !(s2_reg && !s3_reg)
        |=> cnt_reg == $past(cnt_reg) && pre_reg == $past(pre_reg))
        else $error("counter moved without slow tick");
    a_blink_duty: assert property (@(posedge clk) disable iff (!rstn)
        beh_reg == lbp_pkg::LBP_BLINK && running
        |=> pwm_out == ($past(cnt_reg) < $past(bnd_reg.lower)))
        else $error("blink duty not lower bound");
endmodule

// ===== core/lbp_pkg.sv
// Operation
// - Align bit holds all counters at start
// - Align clear: counters run per mode
// - Bit 2 picks main or slow clock in blink
// - Behaviour field: off, breathe, blink, on
// - Off behaviour clears counters and drives output low
// - Bounds writes commit at period end always
// - Each bound byte writable on its own
// - Reads return working bounds and wait values
// - Wait writes commit only when update requested
// - At upper bound hold, then decrement
// - At lower bound hold, then increment
// - Blink duty is the lower bound byte
// - Top wait holds value plus one periods
// - Bottom wait holds value plus one periods
// - Blink prescaler is bottom wait field
// - Update request: set by one, cleared by hardware
package lbp_pkg;
    localparam logic [7:0] CFG_OFFSET = 8'h00;
    localparam logic [7:0] BOUNDS_OFFSET = 8'h04;
    localparam logic [7:0] WAIT_OFFSET = 8'h08;
    localparam int ALIGN_BIT = 3;
    localparam int CLKSEL_BIT = 2;
    localparam int UPDATE_BIT = 6;
    localparam int BEH_LSB = 0;
    localparam logic [1:0] BEH_RESET = 2'h0;
    localparam logic [15:0] BOUNDS_RESET = 16'h0000;
    localparam logic [23:0] WAIT_RESET = 24'h000000;

    typedef enum logic [1:0] {
        LBP_OFF = 2'h0,
        LBP_BREATHE = 2'h1,
        LBP_BLINK = 2'h2,
        LBP_ON = 2'h3
    } lbp_beh_e;

    typedef enum logic [2:0] {
        LBP_UP = 3'h1,
        LBP_HOLD = 3'h2,
        LBP_DOWN = 3'h4
    } lbp_ramp_e;

    typedef struct packed {
        logic [7:0] upper;
        logic [7:0] lower;
    } lbp_bounds_s;

    typedef struct packed {
        logic [11:0] top_wait_periods;
        logic [11:0] bottom_wait_periods;
    } lbp_wait_s;
endpackage

// ===== testbench/lbp_core_tb.sv
module lbp_core_tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk;
    logic rstn;
    logic [7:0] addr;
    logic [31:0] wdata;
    logic [3:0] wbe;
    logic wr;
    logic rd;
    logic [31:0] rdata;
    logic slow_clk_pin;
    logic wdt_timeout;
    logic pwm_out;
    int mismatches;
    int n_checks;
    int cnt;
    logic first;

    lbp_core dut (
        .clk(clk),
        .rstn(rstn),
        .addr(addr),
        .wdata(wdata),
        .wbe(wbe),
        .wr(wr),
        .rd(rd),
        .rdata(rdata),
        .slow_clk_pin(slow_clk_pin),
        .wdt_timeout(wdt_timeout),
        .pwm_out(pwm_out)
    );

    // Main clock, 10 ns period
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Slow pin toggles fast enough to stay cheap; its edges step the counter in the slow-clock blink test
    initial
    begin
        slow_clk_pin = 1'b0;
        forever #370 slow_clk_pin = ~slow_clk_pin;
    end

    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wbe <= be;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        n_checks++;
        if ((rdata & mask) !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED %0t read %h got %h exp %h", $time, a, rdata & mask, exp);
        end
    endtask

    // High cycles of the output over a window, held against a tolerance
    task automatic duty_chk(input int n, input int lo, input int hi);
        cnt = 0;
        repeat (n)
        begin
            @(posedge clk);
            #1;
            if (pwm_out === 1'b1)
                cnt++;
        end
        n_checks++;
        if (cnt < lo || cnt > hi)
        begin
            mismatches++;
            $display("CHECK FAILED %0t high count %0d not in %0d..%0d", $time, cnt, lo, hi);
        end
    endtask

    // Watchdog: the sequence needs a few thousand cycles
    initial
    begin
        #200000;
        mismatches++;
        $display("CHECK FAILED %0t run did not finish", $time);
        test_done();
    end

    initial
    begin
        rstn = 1'b0;
        addr = 8'h00;
        wdata = 32'h0;
        wbe = 4'h0;
        wr = 1'b0;
        rd = 1'b0;
        wdt_timeout = 1'b0;
        mismatches = 0;
        n_checks = 0;
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        rd_chk(8'h00, 32'h0000_004F, 32'h0);
        rd_chk(8'h04, 32'hFFFF_FFFF, 32'h0);
        rd_chk(8'h08, 32'hFFFF_FFFF, 32'h0);
        rd_chk(8'h0C, 32'hFFFF_FFFF, 32'h0);
        // Counters start from zero on leaving off, so the period end is far away
        wr_reg(8'h00, 32'h0000_0001, 4'hF);
        wr_reg(8'h04, 32'h0000_2010, 4'h3);
        rd_chk(8'h04, 32'h0000_FFFF, 32'h0);
        repeat (300) @(posedge clk);
        rd_chk(8'h04, 32'h0000_FFFF, 32'h0000_2010);
        wr_reg(8'h04, 32'h0000_80AA, 4'h2);
        repeat (300) @(posedge clk);
        rd_chk(8'h04, 32'h0000_FFFF, 32'h0000_8010);
        // Wait values must sit in the holding copy until an update is requested
        wr_reg(8'h08, 32'h0000_5000, 4'h7);
        repeat (300) @(posedge clk);
        rd_chk(8'h08, 32'h00FF_FFFF, 32'h0);
        wr_reg(8'h00, 32'h0000_0041, 4'hF);
        rd_chk(8'h00, 32'h0000_004F, 32'h0000_0041);
        repeat (300) @(posedge clk);
        rd_chk(8'h08, 32'h00FF_FFFF, 32'h0000_5000);
        rd_chk(8'h00, 32'h0000_004F, 32'h0000_0001);
        wr_reg(8'h00, 32'h0000_0003, 4'hF);
        repeat (2) @(posedge clk);
        duty_chk(256, 256, 256);
        wr_reg(8'h00, 32'h0000_0000, 4'hF);
        repeat (2) @(posedge clk);
        duty_chk(256, 0, 0);
        // Blink on main clock, half duty, prescaler of one
        wr_reg(8'h00, 32'h0000_0006, 4'hF);
        wr_reg(8'h04, 32'h0000_0080, 4'h3);
        repeat (300) @(posedge clk);
        wr_reg(8'h00, 32'h0000_000E, 4'hF);
        repeat (3) @(posedge clk);
        first = pwm_out;
        duty_chk(300, first ? 300 : 0, first ? 300 : 0);
        wr_reg(8'h00, 32'h0000_0006, 4'hF);
        repeat (2) @(posedge clk);
        duty_chk(512, 250, 262);
        @(posedge clk);
        wdt_timeout <= 1'b1;
        @(posedge clk);
        wdt_timeout <= 1'b0;
        repeat (2) @(posedge clk);
        rd_chk(8'h00, 32'h0000_0003, 32'h0000_0003);
        duty_chk(256, 256, 256);
        // Blink on the slow pin: counter crawls, so output stays high
        wr_reg(8'h00, 32'h0000_000A, 4'hF);
        wr_reg(8'h00, 32'h0000_0002, 4'hF);
        repeat (2) @(posedge clk);
        duty_chk(300, 300, 300);
        // Prescaler of two doubles the high time from the align release
        wr_reg(8'h08, 32'h0000_0001, 4'h7);
        wr_reg(8'h00, 32'h0000_0046, 4'hF);
        repeat (600) @(posedge clk);
        rd_chk(8'h08, 32'h00FF_FFFF, 32'h0000_0001);
        wr_reg(8'h00, 32'h0000_000E, 4'hF);
        wr_reg(8'h00, 32'h0000_0006, 4'hF);
        repeat (2) @(posedge clk);
        duty_chk(300, 250, 258);
        // Breathing between 0 and 1 with zero waits: duty 0,1,1,0,0 then 1
        wr_reg(8'h04, 32'h0000_0100, 4'h3);
        wr_reg(8'h08, 32'h0000_0000, 4'h7);
        wr_reg(8'h00, 32'h0000_0043, 4'hF);
        repeat (300) @(posedge clk);
        rd_chk(8'h04, 32'h0000_FFFF, 32'h0000_0100);
        wr_reg(8'h00, 32'h0000_0009, 4'hF);
        wr_reg(8'h00, 32'h0000_0001, 4'hF);
        repeat (2) @(posedge clk);
        duty_chk(1280, 2, 3);
        test_done();
    end
endmodule
